// >>> design/pwr_seq_defines.vh
// constants for the power and reset sequencer
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define REG_CTRL_ADDR        4'h0
`define REG_STATUS_ADDR      4'h4
`define REG_FINALIZE_ADDR    4'h8
`define REG_ADDR_W           4

// ------------------------------------------------------------
// control register fields and reset values
// ------------------------------------------------------------
`define CTRL_IND_EN_BIT      0
`define CTRL_FAST_EN_BIT     1
`define CTRL_RESET_VAL       2'h0
`define CTRL_IND_EN_RST      1'b0
`define CTRL_FAST_EN_RST     1'b0

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define ST_STATE_LSB         0
`define ST_STATE_W           6
`define ST_ACTIVE_BIT        8
`define ST_BOOT_DONE_BIT     9
`define ST_REF_BIT           10
`define ST_OFF_IND_BIT       11

// ------------------------------------------------------------
// timing: clock and figures in their own units
// ------------------------------------------------------------
`define CLK_MHZ              40'd250
`define ACTIVATE_S           50
`define HARD_RESTART_MS      1000
`define FINALIZE_US          100
`define OFF_DWELL_US         10
// least times round up; all are whole cycles at 4 ns
`define ACTIVATE_CYC         (`ACTIVATE_S * 40'd1000000 * `CLK_MHZ)
`define HARD_RESTART_CYC     (`HARD_RESTART_MS * 40'd1000 * `CLK_MHZ + 40'd1)
`define FINALIZE_CYC         (`FINALIZE_US * `CLK_MHZ)
`define OFF_DWELL_CYC        (`OFF_DWELL_US * `CLK_MHZ)
`define CNT_W                40

`endif

// >>> design/edge_sync.v
// two-stage synchroniser with falling-edge detection
`timescale 1ns/1ps
module edge_sync
(
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        raw_i,
  output reg         level_o,
  output reg         fall_o
);

  reg meta;
  reg sync_q;

  // ------------------------------------------------------------
  // synchroniser; first stage only feeds the second
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta    <= 1'b1;
      sync_q  <= 1'b1;
      level_o <= 1'b1;
      fall_o  <= 1'b0;
    end
    else
    begin
      meta    <= raw_i;
      sync_q  <= meta;
      level_o <= sync_q;
      fall_o  <= level_o & ~sync_q;   // high to low seen after sync
    end
  end

endmodule

// >>> design/pwr_seq.v
// power-on, shutdown and hard restart sequencer with wishbone registers
// How it works
// [R1] host holds power-keep-on high to keep module powered
// [R2] host keeps hard-restart released during power-up
// [R3] activation state reached no sooner than 50 s after power-keep-on high
// [R4] host should not talk to module before activation
// [R5] boot-done indicator rises after full boot when indicator enabled
// [R6] host drives power-keep-on low to request graceful shutdown
// [R7] graceful request: finalize, end processes, then drop reference output
// [R8] enabled trigger line falling edge starts a fast shutdown
// [R9] fast shutdown finalizes then drops reference output as ready-to-off
// [R10] fast shutdown disabled after reset; edges ignored until enabled
// [R11] off indicator optional, disabled by default, shows off state
// [R12] without indicator, host manages power-keep-on to avoid reboot
// [R13] fast shutdown with indicator enabled stays off until repowered
// [R14] without indicator, module reboots itself while supply stays high
// [R15] host holds hard-restart low over 1 s then releases it
// [R16] hard restart is an emergency recovery only
// [R17] host drives hard-restart open-collector only; host_model drives hard_restart_in_n_o high as well as low
// [R18] host keeps digital inputs low while module off or switching; host_model drives fast_trigger_o high whenever keep_i is high and trig_i low
// [R19] reference output on while module on, off once shut down
// [R20] trigger and hard-restart synchronised before edge or duration logic
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "pwr_seq_defines.vh"
module pwr_seq
#(
  parameter [`CNT_W-1:0] ACTIVATE_CYC     = `ACTIVATE_CYC,
  parameter [`CNT_W-1:0] HARD_RESTART_CYC = `HARD_RESTART_CYC,
  parameter [`CNT_W-1:0] FINALIZE_CYC     = `FINALIZE_CYC,
  parameter [`CNT_W-1:0] OFF_DWELL_CYC    = `OFF_DWELL_CYC
)
(
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        power_keep_on_n_i,
  input  wire        hard_restart_in_n_i,
  input  wire        fast_trigger_i,
  input  wire        main_supply_level_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         off_state_indicator_o,
  output reg         ready_to_off_reference_o,
  output reg         active_o
);

  // ------------------------------------------------------------
  // states, one-hot
  // ------------------------------------------------------------
  localparam [5:0] S_OFF   = 6'h01;
  localparam [5:0] S_INIT  = 6'h02;
  localparam [5:0] S_RUN   = 6'h04;
  localparam [5:0] S_FINAL = 6'h08;
  localparam [5:0] S_DOWN  = 6'h10;
  localparam [5:0] S_HALT  = 6'h20;

  reg  [5:0]        state;
  reg  [5:0]        next_state;
  reg  [`CNT_W-1:0] cnt;
  reg  [`CNT_W-1:0] rst_cnt;
  reg               rst_long;
  reg               ind_en;
  reg               fast_en;
  reg               fin_done;
  reg               boot_done;
  wire              trig_fall;
  wire              rst_lvl;
  wire              wb_req;
  wire              wb_wr;
  wire              keep_on;
  wire              restart;
  wire              cnt_zero;

  assign keep_on  = power_keep_on_n_i;
  assign cnt_zero = (cnt == {`CNT_W{1'b0}});
  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];  // commits at the ack edge

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  edge_sync u_trig_sync
  (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .raw_i   (fast_trigger_i),
    .level_o (),
    .fall_o  (trig_fall)          // [R20]
  );

  edge_sync u_rst_sync
  (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .raw_i   (hard_restart_in_n_i),
    .level_o (rst_lvl),           // [R20]
    .fall_o  ()
  );

  // hard restart: low longer than the limit, acted on at release
  assign restart = rst_lvl & rst_long;

  // ------------------------------------------------------------
  // hard-restart low-duration counter
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_cnt  <= {`CNT_W{1'b0}};
      rst_long <= 1'b0;
    end
    else if (rst_lvl)
    begin
      rst_cnt  <= {`CNT_W{1'b0}};
      rst_long <= 1'b0;
    end
    else
    begin
      if (!rst_long)
        rst_cnt <= rst_cnt + {{(`CNT_W-1){1'b0}}, 1'b1};
      if (rst_cnt >= HARD_RESTART_CYC - 1)
        rst_long <= 1'b1;          // [R15]
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      S_OFF:
        if (keep_on && rst_lvl)          // [R2]
          next_state = S_INIT;
      S_INIT:
        if (!keep_on)
          next_state = S_FINAL;
        else if (cnt_zero)
          next_state = S_RUN;            // [R3]
      S_RUN:
        if (!keep_on)
          next_state = S_FINAL;          // [R7]
        else if (trig_fall && fast_en)
          next_state = S_FINAL;          // [R8] [R10]
      S_FINAL:
        if (fin_done || cnt_zero)
          next_state = S_DOWN;           // [R7] [R9]
      S_DOWN:
        if (ind_en)
          next_state = S_HALT;           // [R13]
        else if (cnt_zero)
          next_state = S_OFF;            // [R14]
      S_HALT:
        next_state = S_HALT;
      default:
        next_state = S_OFF;
    endcase
    if (restart && state != S_OFF)
      next_state = S_OFF;
    if (state == S_OFF && !main_supply_level_i)
      next_state = S_OFF;
    if (state == S_DOWN && !ind_en && !main_supply_level_i)
      next_state = S_DOWN;               // stays off without supply
  end

  // ------------------------------------------------------------
  // state register and phase counter
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state     <= S_OFF;
      cnt       <= {`CNT_W{1'b0}};
      boot_done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
      begin
        case (next_state)
          S_INIT:  cnt <= ACTIVATE_CYC - 1;
          S_FINAL: cnt <= FINALIZE_CYC - 1;
          S_DOWN:  cnt <= OFF_DWELL_CYC - 1;
          default: cnt <= {`CNT_W{1'b0}};
        endcase
      end
      else if (!cnt_zero)
        cnt <= cnt - {{(`CNT_W-1){1'b0}}, 1'b1};
      boot_done <= (next_state == S_RUN);
    end
  end

  // ------------------------------------------------------------
  // pin outputs, registered
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ready_to_off_reference_o <= 1'b0;
      off_state_indicator_o    <= 1'b0;
      active_o                 <= 1'b0;
    end
    else
    begin
      // on through init, run and finalize
      ready_to_off_reference_o <= (next_state == S_INIT) | (next_state == S_RUN)
                                | (next_state == S_FINAL);   // [R19]
      // boot-done high in run when indicator enabled, low from finalize on
      off_state_indicator_o    <= ind_en & (next_state == S_RUN); // [R5] [R11]
      active_o                 <= (next_state == S_RUN);
    end
  end

  // ------------------------------------------------------------
  // wishbone slave: control writes, finalize-done strobe
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ind_en   <= `CTRL_IND_EN_RST;      // [R11]
      fast_en  <= `CTRL_FAST_EN_RST;     // [R10]
      fin_done <= 1'b0;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      fin_done <= wb_wr && (wb_adr_i == `REG_FINALIZE_ADDR) && wb_dat_i[0];
      if (wb_wr && wb_adr_i == `REG_CTRL_ADDR)
      begin
        ind_en  <= wb_dat_i[`CTRL_IND_EN_BIT];   // [R11]
        fast_en <= wb_dat_i[`CTRL_FAST_EN_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // read data, registered with the ack
  // ------------------------------------------------------------
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        `REG_CTRL_ADDR:
        begin
          wb_dat_o[`CTRL_IND_EN_BIT]  <= ind_en;
          wb_dat_o[`CTRL_FAST_EN_BIT] <= fast_en;
        end
        `REG_STATUS_ADDR:
        begin
          wb_dat_o[`ST_STATE_LSB +: `ST_STATE_W] <= state;
          wb_dat_o[`ST_ACTIVE_BIT]    <= active_o;
          wb_dat_o[`ST_BOOT_DONE_BIT] <= boot_done;
          wb_dat_o[`ST_REF_BIT]       <= ready_to_off_reference_o;
          wb_dat_o[`ST_OFF_IND_BIT]   <= off_state_indicator_o;
        end
        default:
          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> verif/pwr_seq_asserts.sv
// port checker for the power and reset sequencer
`timescale 1ns/1ps
module pwr_seq_asserts
(
  input wire        clk_i,
  input wire        nrst_i,
  input wire        power_keep_on_n_i,
  input wire        hard_restart_in_n_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        off_state_indicator_o,
  input wire        ready_to_off_reference_o,
  input wire        active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // finalizing, then fully down
  sequence fin_s; !active_o && ready_to_off_reference_o; endsequence
  sequence down_s; !ready_to_off_reference_o && !off_state_indicator_o; endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("access not acked");
  unmap_rd_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 4'hc |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  act_ref_a: assert property (active_o |-> ready_to_off_reference_o)
    else $error("active without reference");
  ind_run_a: assert property (off_state_indicator_o |-> active_o)
    else $error("indicator outside run");
  act_wait_a: assert property ($rose(active_o) |-> $past(ready_to_off_reference_o, 8) && !$past(active_o, 8))
    else $error("activation too early");
  graceful_a: assert property ($fell(power_keep_on_n_i) && active_o |-> ##[1:4] fin_s ##[1:30] down_s)
    else $error("graceful shutdown sequence broken");
  ref_fall_a: assert property ($fell(ready_to_off_reference_o) |-> !$past(active_o) || !$past(hard_restart_in_n_i, 6))
    else $error("reference dropped without finalizing");
endmodule
bind pwr_seq pwr_seq_asserts chk
(
  .clk_i                    (clk_i),
  .nrst_i                   (nrst_i),
  .power_keep_on_n_i        (power_keep_on_n_i),
  .hard_restart_in_n_i      (hard_restart_in_n_i),
  .wb_cyc_i                 (wb_cyc_i),
  .wb_stb_i                 (wb_stb_i),
  .wb_we_i                  (wb_we_i),
  .wb_adr_i                 (wb_adr_i),
  .wb_dat_o                 (wb_dat_o),
  .wb_ack_o                 (wb_ack_o),
  .off_state_indicator_o    (off_state_indicator_o),
  .ready_to_off_reference_o (ready_to_off_reference_o),
  .active_o                 (active_o)
);

// >>> verif/host_model.sv
// host side driver of the module control pins
`timescale 1ns/1ps
module host_model
(
  input  wire clk_i,
  input  wire keep_i,
  input  wire restart_i,
  input  wire trig_i,
  input  wire supply_i,
  output reg  power_keep_on_n_o,
  output reg  hard_restart_in_n_o,
  output reg  fast_trigger_o,
  output reg  main_supply_level_o
);
  // pins idle low, restart released
  initial
  begin
    power_keep_on_n_o = 1'b0;
    hard_restart_in_n_o = 1'b1;
    fast_trigger_o = 1'b0;
    main_supply_level_o = 1'b0;
  end
  // pins change only just after an edge
  always @(posedge clk_i)
  begin
    power_keep_on_n_o <= keep_i;
    hard_restart_in_n_o <= !restart_i;
    fast_trigger_o <= keep_i && !trig_i;
    main_supply_level_o <= supply_i;
  end
endmodule

// >>> verif/pwr_seq_bench.sv
// self-checking bench for the power and reset sequencer
`timescale 1ns/1ps
module pwr_seq_bench;
  reg         clk_i = 1'b0;
  reg         nrst_i = 1'b0;
  reg         keep = 1'b0;
  reg         rs = 1'b0;
  reg         trg = 1'b0;
  reg         sup = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg  [3:0]  sel = 4'hf;
  reg  [31:0] wdat = 32'h0;
  reg  [31:0] got;
  wire [31:0] rdat;
  wire        ack, ind, refo, act, pk_n, hr_n, ft, ms;
  integer     fail_count = 0, checked = 0, st = 1, ctl = 0, n;
  always #2 clk_i = ~clk_i;
  host_model host (.clk_i(clk_i), .keep_i(keep), .restart_i(rs), .trig_i(trg), .supply_i(sup),
    .power_keep_on_n_o(pk_n), .hard_restart_in_n_o(hr_n), .fast_trigger_o(ft), .main_supply_level_o(ms));
  pwr_seq #(.ACTIVATE_CYC(40'd20), .HARD_RESTART_CYC(40'd10), .FINALIZE_CYC(40'd8), .OFF_DWELL_CYC(40'd4)) dut
    (.clk_i(clk_i), .nrst_i(nrst_i), .power_keep_on_n_i(pk_n), .hard_restart_in_n_i(hr_n), .fast_trigger_i(ft),
     .main_supply_level_i(ms), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
     .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .off_state_indicator_o(ind),
     .ready_to_off_reference_o(refo), .active_o(act));
  task check(input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // classic single wishbone cycle, held until ack
  task wb(input w, input [3:0] a, input [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task run(input integer c);
    repeat (c) @(posedge clk_i);
  endtask
  // wait for a pin pattern, bounded
  task till(input [2:0] v);
    n = 0;
    while ({ind, refo, act} !== v && n < 200)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    check(n < 200, 1);
  endtask
  // model state against pins and status
  task pins;
    check({ind, refo, act}, {st == 4 && ctl[0], st == 2 || st == 4 || st == 8, st == 4});
  endtask
  task stat;
    wb(1'b0, 4'h4, 32'h0);
    check(got & 32'hf3f, {st == 4 && ctl[0], st == 2 || st == 4 || st == 8, st == 4, st == 4, 2'b0, st[5:0]});
  endtask
  task wrap_up;
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    fail_count = fail_count + 1;
    wrap_up;
  end
  // main sequence
  initial
  begin
    void'($urandom(64));
    run(10);
    nrst_i <= 1'b1;
    run(1);
    wb(1'b0, 4'h0, 32'h0);
    check(got, 32'h0);
    wb(1'b0, 4'hc, 32'h0);
    check(got, 32'h0);
    stat;
    sup <= 1'b0;
    keep <= 1'b1;
    run(30);
    pins;
    sup <= 1'b1;
    st = 4;
    till(3'b011);
    check(n >= 20, 1);
    stat;
    trg <= 1'b1;
    run(10);
    pins;
    trg <= 1'b0;
    ctl = 3;
    sel <= 4'h1 | 4'($urandom);
    wb(1'b1, 4'h0, ($urandom << 2) | 32'h3);
    sel <= 4'he;
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    check(got & 32'h3, 32'h3);
    pins;
    trg <= 1'b1;
    st = 32;
    till(3'b000);
    check(n >= 8, 1);
    run(20);
    stat;
    ctl = 2;
    sel <= 4'hf;
    wb(1'b1, 4'h0, 32'h2);
    trg <= 1'b0;
    rs <= 1'b1;
    run(16);
    rs <= 1'b0;
    st = 4;
    till(3'b011);
    check(n >= 20, 1);
    wb(1'b1, 4'h0, 32'h2);
    trg <= 1'b1;
    till(3'b000);
    till(3'b011);
    pins;
    trg <= 1'b0;
    ctl = 0;
    wb(1'b1, 4'h0, 32'h0);
    keep <= 1'b0;
    st = 8;
    run(4);
    pins;
    wb(1'b1, 4'h8, 32'h1);
    run(1);
    st = 16;
    pins;
    st = 1;
    till(3'b000);
    run(10);
    stat;
    keep <= 1'b1;
    st = 4;
    till(3'b011);
    nrst_i <= 1'b0;
    st = 1;
    run(2);
    pins;
    nrst_i <= 1'b1;
    run(2);
    st = 2;
    pins;
    wb(1'b0, 4'h0, 32'h0);
    check(got, 32'h0);
    wrap_up;
  end
endmodule
